// ### pkg/esia_pkg.sv
// Constants for the event and software interrupt arbiter
package esia_pkg;
    // ****************************************
    // Source count and layout
    // ****************************************
    localparam int NUM_EVT = 9;
    localparam int NUM_SW  = 7;
    localparam int NUM_SRC = 16;
    // Field positions inside a priority register
    localparam int FLD_LO_LSB = 0;
    localparam int FLD_HI_LSB = 4;
    localparam int FLD_W      = 3;
    // Nonzero field value v maps to effective priority 8 + v
    localparam logic [3:0] UART0_RX_FIELD_A_EVT_BASE = 4'h8;
    localparam logic [3:0] UART0_RX_FIELD_A_NONE     = 4'h0;
    localparam logic [3:0] UART0_RX_FIELD_A_TOP      = 4'hf;
    // ****************************************
    // Vector addresses
    // ****************************************
    localparam logic [15:0] VEC_EXT0    = 16'h0080;
    localparam logic [15:0] VEC_TMR0    = 16'h0084;
    localparam logic [15:0] VEC_EXT1    = 16'h0088;
    localparam logic [15:0] VEC_TMR1    = 16'h008c;
    localparam logic [15:0] VEC_TMR2    = 16'h0090;
    localparam logic [15:0] VEC_U0RX    = 16'h00a0;
    localparam logic [15:0] VEC_U0TX    = 16'h00a4;
    localparam logic [15:0] VEC_U1RX    = 16'h00a8;
    localparam logic [15:0] VEC_U1TX    = 16'h00ac;
    localparam logic [15:0] VEC_SW_BASE = 16'h0100;
    localparam logic [15:0] VEC_SW_STEP = 16'h0004;
    localparam logic [15:0] VEC_SW_LAST = 16'h0118;
    localparam logic [15:0] VEC_RST     = 16'h0000;
    // ****************************************
    // Registered state
    // ****************************************
    typedef struct packed {
        logic        req;
        logic [15:0] vector;
        logic [3:0]  uart0_rx_field_a;
    } esia_state_t;
endpackage

// ### rtl/esia_arbiter.sv
// Event and software interrupt arbiter facing the processor core
`timescale 1ns/10ps
module esia_arbiter (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        ext0_pending,
    input  wire logic        timer0_overflow_flag,
    input  wire logic        ext1_pending,
    input  wire logic        timer1_overflow_flag,
    input  wire logic        timer2_overflow_flag,
    input  wire logic        timer2_external_flag,
    input  wire logic        uart0_rx_flag,
    input  wire logic        uart0_tx_flag,
    input  wire logic        uart1_rx_flag,
    input  wire logic        uart1_tx_flag,
    input  wire logic        global_irq_enable,
    input  wire logic        ext0_irq_en,
    input  wire logic        timer0_irq_en,
    input  wire logic        ext1_irq_en,
    input  wire logic        timer1_irq_en,
    input  wire logic        timer2_irq_en,
    input  wire logic        uart0_rx_irq_en,
    input  wire logic        uart0_tx_irq_en,
    input  wire logic        uart1_rx_irq_en,
    input  wire logic        uart1_tx_irq_en,
    input  wire logic [7:0]  priority_reg_0,
    input  wire logic [7:0]  priority_reg_1,
    input  wire logic [7:0]  priority_reg_2,
    input  wire logic [7:0]  priority_reg_4,
    input  wire logic [7:0]  priority_reg_5,
    input  wire logic        soft_req_1,
    input  wire logic        soft_req_2,
    input  wire logic        soft_req_3,
    input  wire logic        soft_req_4,
    input  wire logic        soft_req_5,
    input  wire logic        soft_req_6,
    input  wire logic        soft_req_7,
    input  wire logic        soft_en_1,
    input  wire logic        soft_en_2,
    input  wire logic        soft_en_3,
    input  wire logic        soft_en_4,
    input  wire logic        soft_en_5,
    input  wire logic        soft_en_6,
    input  wire logic        soft_en_7,
    output logic             irq_req,
    output logic [15:0]      irq_vector,
    output logic [3:0]       irq_uart0_rx_field_a
);
    // ****************************************
    // Source table, index order is tie ranking order, lower index wins
    // ****************************************
    logic [esia_pkg::NUM_SRC-1:0] act;
    logic [2:0]                   fld  [esia_pkg::NUM_EVT];
    logic [3:0]                   eff  [esia_pkg::NUM_SRC];
    logic [15:0]                  vec  [esia_pkg::NUM_SRC];
    logic [esia_pkg::NUM_SW-1:0]  sreq;
    logic [esia_pkg::NUM_SW-1:0]  sen;
    logic                         gen;

    assign sreq = {soft_req_7, soft_req_6, soft_req_5, soft_req_4,
                   soft_req_3, soft_req_2, soft_req_1};
    assign sen  = {soft_en_7, soft_en_6, soft_en_5, soft_en_4,
                   soft_en_3, soft_en_2, soft_en_1};
    assign gen  = global_irq_enable;

    assign act[0] = gen & ext0_irq_en & ext0_pending;
    assign fld[0] = priority_reg_0[esia_pkg::FLD_LO_LSB +: esia_pkg::FLD_W];
    assign vec[0] = esia_pkg::VEC_EXT0;
    assign act[1] = gen & timer0_irq_en & timer0_overflow_flag;
    assign fld[1] = priority_reg_0[esia_pkg::FLD_HI_LSB +: esia_pkg::FLD_W];
    assign vec[1] = esia_pkg::VEC_TMR0;
    assign act[2] = gen & ext1_irq_en & ext1_pending;
    assign fld[2] = priority_reg_1[esia_pkg::FLD_LO_LSB +: esia_pkg::FLD_W];
    assign vec[2] = esia_pkg::VEC_EXT1;
    assign act[3] = gen & timer1_irq_en & timer1_overflow_flag;
    assign fld[3] = priority_reg_1[esia_pkg::FLD_HI_LSB +: esia_pkg::FLD_W];
    assign vec[3] = esia_pkg::VEC_TMR1;
    assign act[4] = gen & timer2_irq_en & (timer2_overflow_flag | timer2_external_flag);
    assign fld[4] = priority_reg_2[esia_pkg::FLD_LO_LSB +: esia_pkg::FLD_W];
    assign vec[4] = esia_pkg::VEC_TMR2;
    assign act[5] = gen & uart0_rx_irq_en & uart0_rx_flag;
    assign fld[5] = priority_reg_4[esia_pkg::FLD_LO_LSB +: esia_pkg::FLD_W];
    assign vec[5] = esia_pkg::VEC_U0RX;
    assign act[6] = gen & uart0_tx_irq_en & uart0_tx_flag;
    assign fld[6] = priority_reg_4[esia_pkg::FLD_HI_LSB +: esia_pkg::FLD_W];
    assign vec[6] = esia_pkg::VEC_U0TX;
    assign act[7] = gen & uart1_rx_irq_en & uart1_rx_flag;
    assign fld[7] = priority_reg_5[esia_pkg::FLD_LO_LSB +: esia_pkg::FLD_W];
    assign vec[7] = esia_pkg::VEC_U1RX;
    assign act[8] = gen & uart1_tx_irq_en & uart1_tx_flag;
    assign fld[8] = priority_reg_5[esia_pkg::FLD_HI_LSB +: esia_pkg::FLD_W];
    assign vec[8] = esia_pkg::VEC_U1TX;

    genvar g;
    generate
        for (g = 0; g < esia_pkg::NUM_EVT; g++) begin : g_evt
            assign eff[g] = (fld[g] == 3'h0) ? esia_pkg::UART0_RX_FIELD_A_NONE
                                             : esia_pkg::UART0_RX_FIELD_A_EVT_BASE | {1'b0, fld[g]};
        end
        for (g = 0; g < esia_pkg::NUM_SW; g++) begin : g_sw
            assign act[esia_pkg::NUM_EVT + g] = sreq[g] & sen[g];
            assign eff[esia_pkg::NUM_EVT + g] = 4'(g + 1);
            assign vec[esia_pkg::NUM_EVT + g] = esia_pkg::VEC_SW_BASE
                                              + 16'(g) * esia_pkg::VEC_SW_STEP;
        end
    endgenerate

    // ****************************************
    // Arbitration and output state
    // ****************************************
    esia_pkg::esia_state_t state;
    esia_pkg::esia_state_t next_state;

    // One register stage keeps outputs glitch free at the cost of a cycle
    always_comb begin
        logic [3:0]  best_p;
        logic [15:0] best_v;
        best_p = esia_pkg::UART0_RX_FIELD_A_NONE;
        best_v = esia_pkg::VEC_RST;
        for (int i = 0; i < esia_pkg::NUM_SRC; i++) begin
            if (act[i] && (eff[i] > best_p)) begin
                best_p = eff[i];
                best_v = vec[i];
            end
        end
        // winner only, priority zero never wins
        next_state.req    = (best_p != esia_pkg::UART0_RX_FIELD_A_NONE);
        next_state.vector = best_v;
        next_state.uart0_rx_field_a   = best_p;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= '{req: 1'b0, vector: esia_pkg::VEC_RST, uart0_rx_field_a: esia_pkg::UART0_RX_FIELD_A_NONE};
        end else begin
            state <= next_state;
        end
    end

    assign irq_req    = state.req;
    assign irq_vector = state.vector;
    assign irq_uart0_rx_field_a   = state.uart0_rx_field_a;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_ext0_top;
        (act[0] && fld[0] == 3'h7) |=>
            irq_req && irq_vector == esia_pkg::VEC_EXT0 && irq_uart0_rx_field_a == esia_pkg::UART0_RX_FIELD_A_TOP;
    endproperty
    a_ext0_top: assert property (p_ext0_top) else $error("ext0 not served");

    property p_tmr0_top;
        (!act[0] && act[1] && fld[1] == 3'h7) |=> irq_vector == esia_pkg::VEC_TMR0;
    endproperty
    a_tmr0_top: assert property (p_tmr0_top) else $error("timer0 not served");

    property p_tmr2_ext;
        (act[3:0] == 4'h0 && gen && timer2_irq_en && timer2_external_flag
            && fld[4] == 3'h7) |=> irq_vector == esia_pkg::VEC_TMR2;
    endproperty
    a_tmr2_ext: assert property (p_tmr2_ext) else $error("timer2 external flag lost");

    property p_u1tx_only;
        (act == 16'h0100 && fld[8] != 3'h0) |=>
            irq_vector == esia_pkg::VEC_U1TX && irq_uart0_rx_field_a == 4'h8 + {1'b0, $past(fld[8])};
    endproperty
    a_u1tx_only: assert property (p_u1tx_only) else $error("uart1 tx wrong");

    property p_sw_uart0_rx_field_a;
        (act[15:9] == 7'h40 && act[8:0] == 9'h000) |=> irq_uart0_rx_field_a == 4'h7;
    endproperty
    a_sw_uart0_rx_field_a: assert property (p_sw_uart0_rx_field_a) else $error("software priority wrong");

    property p_sw_vec;
        (act[15] && act[8:0] == 9'h000) |=> irq_vector == esia_pkg::VEC_SW_LAST;
    endproperty
    a_sw_vec: assert property (p_sw_vec) else $error("software vector wrong");

    property p_zero_uart0_rx_field_a;
        irq_req |-> irq_uart0_rx_field_a != esia_pkg::UART0_RX_FIELD_A_NONE;
    endproperty
    a_zero_uart0_rx_field_a: assert property (p_zero_uart0_rx_field_a) else $error("priority zero presented");

    property p_one_is_nine;
        (act == 16'h0001 && fld[0] == 3'h1) ##1 act == 16'h0001 |-> irq_uart0_rx_field_a == 4'h9;
    endproperty
    a_one_is_nine: assert property (p_one_is_nine) else $error("field one not nine");

    property p_global_off;
        (!global_irq_enable && act[15:9] == 7'h00) |=> !irq_req;
    endproperty
    a_global_off: assert property (p_global_off) else $error("global enable ignored");

    property p_tie_rank;
        (act[5] && act[6] && act[4:0] == 5'h00 && eff[5] == eff[6]
            && eff[5] == esia_pkg::UART0_RX_FIELD_A_TOP) |=> irq_vector == esia_pkg::VEC_U0RX;
    endproperty
    a_tie_rank: assert property (p_tie_rank) else $error("tie rank wrong");

    property p_idle;
        (act == 16'h0000) |=> !irq_req && irq_uart0_rx_field_a == esia_pkg::UART0_RX_FIELD_A_NONE;
    endproperty
    a_idle: assert property (p_idle) else $error("request without source");

    c_ext0:  cover property (act[0] ##1 irq_vector == esia_pkg::VEC_EXT0);
    c_sw:    cover property (act[15] ##1 irq_vector == esia_pkg::VEC_SW_LAST);
    c_tie:   cover property (act[5] && act[6] && eff[5] == eff[6] && eff[5] != 4'h0);
    c_zero:  cover property (act[1] && fld[1] == 3'h0);
endmodule // esia_arbiter

// ### tb/esia_core_model.sv
// Processor core model taking vectored requests
`timescale 1ns/10ps
module esia_core_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vector,
    input  wire logic [3:0]  irq_uart0_rx_field_a,
    output int               taken
);
    // ****************************************
    // Request intake
    // ****************************************
    // take presented winner
    // Counts cycles only; no acknowledge path exists to model
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            taken <= 0;
        end else if (irq_req === 1'b1 && irq_uart0_rx_field_a !== 4'h0 && irq_vector !== 16'h0000) begin
            taken <= taken + 1;
        end
    end
endmodule // esia_core_model

// ### tb/event_soft_interrupt_arbiter_tb.sv
// Self-checking bench for the interrupt arbiter
`timescale 1ns/10ps
module event_soft_interrupt_arbiter_tb;
    logic        sys_clk    = 1'b0;
    logic        rst_n      = 1'b0;
    logic        gie        = 1'b0;
    logic        t2x        = 1'b0;
    logic [8:0]  flg        = 9'h000;
    logic [8:0]  en         = 9'h000;
    logic [7:0]  pr [6]     = '{default: 8'h00};
    logic [7:1]  swr        = 7'h00;
    logic [7:1]  swe        = 7'h00;
    logic        irq_req;
    logic [15:0] irq_vector;
    logic [3:0]  irq_uart0_rx_field_a;
    int          num_errors = 0;
    int          checked    = 0;
    int          cyc        = 0;
    int          n_req      = 0;
    int          taken;
    logic [15:0] vec [9]    = '{16'h0080, 16'h0084, 16'h0088, 16'h008c, 16'h0090,
                                16'h00a0, 16'h00a4, 16'h00a8, 16'h00ac};
    int          reg_of [9] = '{0, 0, 1, 1, 2, 4, 4, 5, 5};
    int          lsb_of [9] = '{0, 4, 0, 4, 0, 0, 4, 0, 4};
    always #20 sys_clk = ~sys_clk;
    esia_arbiter dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .global_irq_enable(gie),
        .ext0_pending(flg[0]), .timer0_overflow_flag(flg[1]), .ext1_pending(flg[2]),
        .timer1_overflow_flag(flg[3]), .timer2_overflow_flag(flg[4]),
        .timer2_external_flag(t2x), .uart0_rx_flag(flg[5]), .uart0_tx_flag(flg[6]),
        .uart1_rx_flag(flg[7]), .uart1_tx_flag(flg[8]),
        .ext0_irq_en(en[0]), .timer0_irq_en(en[1]), .ext1_irq_en(en[2]),
        .timer1_irq_en(en[3]), .timer2_irq_en(en[4]), .uart0_rx_irq_en(en[5]),
        .uart0_tx_irq_en(en[6]), .uart1_rx_irq_en(en[7]), .uart1_tx_irq_en(en[8]),
        .priority_reg_0(pr[0]), .priority_reg_1(pr[1]), .priority_reg_2(pr[2]),
        .priority_reg_4(pr[4]), .priority_reg_5(pr[5]),
        .soft_req_1(swr[1]), .soft_req_2(swr[2]), .soft_req_3(swr[3]), .soft_req_4(swr[4]),
        .soft_req_5(swr[5]), .soft_req_6(swr[6]), .soft_req_7(swr[7]),
        .soft_en_1(swe[1]), .soft_en_2(swe[2]), .soft_en_3(swe[3]), .soft_en_4(swe[4]),
        .soft_en_5(swe[5]), .soft_en_6(swe[6]), .soft_en_7(swe[7]),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_uart0_rx_field_a(irq_uart0_rx_field_a));
    esia_core_model core (
        .sys_clk(sys_clk), .rst_n(rst_n), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_uart0_rx_field_a(irq_uart0_rx_field_a), .taken(taken));
    // ****************************************
    // Reference model and checks
    // ****************************************
    // Strict greater keeps the lower rank on ties
    function automatic void model(output logic r, output logic [15:0] v, output logic [3:0] p);
        int bp;
        int f;
        bp = 0;
        v = 16'h0000;
        for (int i = 0; i < 9; i++) begin
            f = (pr[reg_of[i]] >> lsb_of[i]) & 7;
            if ((flg[i] || (i == 4 && t2x)) && en[i] && gie && f != 0 && 8 + f > bp) begin
                bp = 8 + f;
                v = vec[i];
            end
        end
        for (int n = 1; n < 8; n++) begin
            if (swr[n] && swe[n] && n > bp) begin
                bp = n;
                v = 16'h0100 + 16'(4 * (n - 1));
            end
        end
        p = 4'(bp);
        r = (bp != 0);
    endfunction
    task automatic cmp(input string what, input logic [20:0] exp, input logic [20:0] seen);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input string what);
        logic [20:0] e;
        logic        rs;
        model(e[20], e[19:4], e[3:0]);
        rs = rst_n;
        @(posedge sys_clk);
        #1;
        if (rs !== 1'b1) e = 21'h000000;
        n_req = n_req + int'(e[20]);
        cmp(what, e, {irq_req, irq_vector, irq_uart0_rx_field_a});
    endtask
    task automatic idle();
        flg = 9'h000;
        en = 9'h000;
        gie = 1'b0;
        t2x = 1'b0;
        swr = 7'h00;
        swe = 7'h00;
        pr = '{default: 8'h00};
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(91));
        swr = 7'h7f;
        swe = 7'h7f;
        repeat (8) tick("reset");
        rst_n = 1'b1;
        $display("test reset finished");
        // Field 8 drops the enable, field 9 the global enable
        for (int i = 0; i < 9; i++) begin
            for (int f = 0; f < 10; f++) begin
                idle();
                swr[7] = 1'b1;
                swe[7] = 1'b1;
                gie = (f != 9);
                en[i] = (f != 8);
                if (i == 4 && f % 2 == 1) t2x = 1'b1;
                else flg[i] = 1'b1;
                pr[reg_of[i]][lsb_of[i] +: 3] = (f > 7) ? 3'h7 : 3'(f);
                tick("evt");
            end
        end
        $display("test single finished");
        idle();
        flg = 9'h1ff;
        en = 9'h1ff;
        gie = 1'b1;
        pr = '{default: 8'h33};
        for (int i = 0; i < 9; i++) begin
            tick("tie");
            flg[i] = 1'b0;
        end
        $display("test tie finished");
        // Top level tie, then a field of one held for two cycles
        flg = 9'h060;
        pr[4] = 8'h77;
        tick("tie top");
        flg = 9'h001;
        pr[0] = 8'h01;
        repeat (2) tick("field one");
        $display("test pair finished");
        idle();
        swr = 7'h7f;
        swe = 7'h7f;
        for (int n = 7; n >= 1; n--) begin
            tick("soft");
            swe[n] = 1'b0;
        end
        tick("soft");
        $display("test soft finished");
        rst_n = 1'b0;
        swe = 7'h7f;
        repeat (2) tick("reset");
        n_req = 0;
        rst_n = 1'b1;
        repeat (1500) begin
            flg = 9'($urandom);
            en = 9'($urandom);
            gie = 1'($urandom);
            t2x = 1'($urandom);
            foreach (pr[k]) pr[k] = 8'($urandom);
            swr = 7'($urandom);
            swe = 7'($urandom);
            tick("random");
        end
        idle();
        repeat (2) tick("drain");
        cmp("core taken", 21'(n_req), 21'(taken));
        $display("test random finished");
        end_sim();
    end
endmodule // event_soft_interrupt_arbiter_tb
